// file: core/ccr_io_gap.v
// Purpose: Enforces the minimum bus-clock spacing between I/O accesses.
// Assumes: ioStart pulses on the cycle an I/O access begins.
// Notes:   Code 7h disables spacing; codes 0h-6h give 2^code clocks.
`timescale 1ns/100ps
`default_nettype none
`include "ccr_map.vh"

module ccr_io_gap #(
  parameter CNT_W = `CCR_GAP_CNT_W
) (
  input  wire             sys_clk,
  input  wire             reset_n,
  input  wire [2:0]       gapCode,
  input  wire             ioStart,
  output wire             ioGapBusy
);

  reg  [CNT_W-1:0] gapCnt_ff;
  reg  [CNT_W-1:0] nxt_gapCnt;

  function [CNT_W-1:0] gapClocks;
    input [2:0] code;
    begin
      if (code == `CCR_GAP_NONE) begin
        gapClocks = {CNT_W{1'b0}};
      end else begin
        gapClocks = {{(CNT_W-1){1'b0}}, 1'b1} << code;
      end
    end
  endfunction

  always @* begin
    nxt_gapCnt = gapCnt_ff;
    if (ioStart) begin
      nxt_gapCnt = gapClocks(gapCode);
    end else if (gapCnt_ff != {CNT_W{1'b0}}) begin
      nxt_gapCnt = gapCnt_ff - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      gapCnt_ff <= {CNT_W{1'b0}};
    end else begin
      gapCnt_ff <= nxt_gapCnt;
    end
  end

  assign ioGapBusy = (gapCnt_ff != {CNT_W{1'b0}});

endmodule // ccr_io_gap
`default_nettype wire

// file: core/ccr_map.vh
// Purpose: Constants for the processor configuration control register bank.
// Assumes: Byte address of a register is four times its index.
// Notes:   Included by every file of the bank; definitions only.
`ifndef CCR_MAP_VH
`define CCR_MAP_VH

`define CCR_ADDR_W        10
// Register indexes; byte address is index times four
`define CCR_IDX_MGMT_SPC  8'hc1
`define CCR_IDX_BUS_PWR   8'hc2
`define CCR_IDX_MAP_LOCK  8'hc3
`define CCR_IDX_IO_REC    8'he8
`define CCR_IDX_REG_ALLOC 8'he9
`define CCR_IDX_MGMT_MODE 8'hea
`define CCR_IDX_STATUS    8'hf0
// Open window when the map is disabled
`define CCR_IDX_OPEN_LO   8'hc0
`define CCR_IDX_OPEN_HI   8'hcf
`define CCR_IDX_DEV_ID0   8'hfe
`define CCR_IDX_DEV_ID1   8'hff
`define CCR_MAP_ALL       4'h1

// Writable bit masks per register
`define CCR_MASK_MGMT_SPC  8'h86
`define CCR_MASK_BUS_PWR   8'h9e
`define CCR_MASK_MAP_LOCK  8'hf7
`define CCR_MASK_IO_REC    8'h87
`define CCR_MASK_REG_ALLOC 8'h21
`define CCR_MASK_MGMT_MODE 8'h43
// Bits guarded by the management lock
`define CCR_LOCK_MGMT_SPC  8'h86
`define CCR_LOCK_MAP_LOCK  8'h02
`define CCR_LOCK_MGMT_MODE 8'h41

// Reset values
`define CCR_RST_MGMT_SPC   8'h00
`define CCR_RST_BUS_PWR    8'h00
`define CCR_RST_MAP_LOCK   8'h00
`define CCR_RST_IO_REC     8'h05
`define CCR_RST_REG_ALLOC  8'h00
`define CCR_RST_MGMT_MODE  8'h00

// Field positions
`define CCR_B_R3_SPACE     7
`define CCR_B_MEM_ACCESS   2
`define CCR_B_PINS_EN      1
`define CCR_B_SUSPEND_REQUEST_N_PIN     7
`define CCR_B_LOW_WP       4
`define CCR_B_SUSPEND_REQUEST_N_HALT    3
`define CCR_B_FREEZE_NW    2
`define CCR_B_SLOW_STROBE  1
`define CCR_B_MAP_HI       7
`define CCR_B_MAP_LO       4
`define CCR_B_LIN_BURST    2
`define CCR_B_NMI_EN       1
`define CCR_B_MGMT_LOCK    0
`define CCR_B_IDENT_EN     7
`define CCR_B_GAP_HI       2
`define CCR_B_GAP_LO       0
`define CCR_B_REGION_EN    5
`define CCR_B_WRITETHROUGH_ALLOCATE     0
`define CCR_B_NEST         6
`define CCR_B_R3_WP        1
`define CCR_B_ENH_MODE     0

// Low region bounds, 640 KByte to 1 MByte
`define CCR_LOW_REGION_LO  32'h000a0000
`define CCR_LOW_REGION_HI  32'h00100000
`define CCR_GAP_NONE       3'h7
`define CCR_GAP_CNT_W      7

`endif

// file: core/ccr_regs.v
// Purpose: Configuration control register bank with APB access.
// Assumes: Core events are single-cycle pulses synchronous to sys_clk.
// Notes:   Zero wait states; hidden or unmapped addresses answer pslverr.
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "ccr_map.vh"

module ccr_regs (
  input  wire                   sys_clk,
  input  wire                   reset_n,
  // APB slave
  input  wire                   psel,
  input  wire                   penable,
  input  wire                   pwrite,
  input  wire [`CCR_ADDR_W-1:0] paddr,
  input  wire [31:0]            pwdata,
  input  wire [3:0]             pstrb,
  output reg  [31:0]            prdata,
  output wire                   pready,
  output wire                   pslverr,
  // Core state and events
  input  wire                   mgmtMode,
  input  wire                   mgmtEntry,
  input  wire                   resumeFromMgmt,
  input  wire                   mgmtInterrupt,
  input  wire                   nmiRequest,
  input  wire                   haltInstruction,
  input  wire                   wakeEvent,
  input  wire                   suspendRequestN,
  input  wire                   identExecute,
  input  wire                   nwWriteRequest,
  input  wire                   nwWriteValue,
  input  wire                   ioStart,
  input  wire                   burstReadyN,
  input  wire                   strobeRequest,
  input  wire [31:0]            accessAddr,
  input  wire                   accessCacheable,
  input  wire                   accessWrite,
  input  wire                   accessRegion3,
  input  wire [1:0]             burstFirst,
  input  wire [1:0]             burstBeat,
  // Core controls
  output wire                   suspendAckNOut,
  output wire                   suspendAckNOe,
  output wire                   suspended,
  output wire                   writeProtectHit,
  output reg                    notWritethroughFlag,
  output reg                    busIdle,
  output reg                    addressStrobeN,
  output reg  [1:0]             burstAddr,
  output wire                   nmiAccept,
  output wire                   mgmtIntAccept,
  output wire                   mgmtPinsEnable,
  output wire                   mgmtMemoryAccess,
  output wire                   region3WriteAllow,
  output wire                   identFlagWritable,
  output wire                   identInvalidOpcode,
  output wire                   ioGapBusy,
  output wire [7:0]             regionEnable,
  output wire                   writethroughAllocate,
  output wire                   enhancedMgmtMode
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg  [7:0] mgmtSpace_ff;
  reg  [7:0] busPower_ff;
  reg  [7:0] mapLock_ff;
  reg  [7:0] ioRecovery_ff;
  reg  [7:0] regionAlloc_ff;
  reg  [7:0] mgmtModeCtl_ff;
  reg  [7:0] nxt_mgmtSpace;
  reg  [7:0] nxt_busPower;
  reg  [7:0] nxt_mapLock;
  reg  [7:0] nxt_ioRecovery;
  reg  [7:0] nxt_regionAlloc;
  reg  [7:0] nxt_mgmtModeCtl;
  reg  [7:0] rdByte;
  reg        strobePending_ff;

  wire [7:0] regIdx;
  wire       aligned;
  wire       hit;
  wire       wrEn;
  wire       lockActive;
  wire       mapAll;
  wire [7:0] wrByte;

  assign regIdx = paddr[9:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign mapAll  = (mapLock_ff[`CCR_B_MAP_HI:`CCR_B_MAP_LO] == `CCR_MAP_ALL);
  assign wrByte  = pwdata[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  // map window check
  function visible;
    input [7:0] idx;
    input       all;
    begin
      visible = all ||
                (idx >= `CCR_IDX_OPEN_LO && idx <= `CCR_IDX_OPEN_HI) ||
                idx == `CCR_IDX_DEV_ID0 || idx == `CCR_IDX_DEV_ID1;
    end
  endfunction

  function implemented;
    input [7:0] idx;
    begin
      implemented = idx == `CCR_IDX_MGMT_SPC || idx == `CCR_IDX_BUS_PWR ||
                    idx == `CCR_IDX_MAP_LOCK || idx == `CCR_IDX_IO_REC ||
                    idx == `CCR_IDX_REG_ALLOC || idx == `CCR_IDX_MGMT_MODE ||
                    idx == `CCR_IDX_STATUS;
    end
  endfunction

  function [7:0] merge;
    input [7:0] old;
    input [7:0] data;
    input [7:0] mask;
    input [7:0] locked;
    input       blocked;
    reg   [7:0] open;
    begin
      open  = blocked ? (mask & ~locked) : mask;
      merge = (old & ~open) | (data & open);
    end
  endfunction

  assign hit     = aligned && implemented(regIdx) && visible(regIdx, mapAll);
  assign wrEn    = psel && penable && pwrite && hit && pstrb[0];
  assign pready  = 1'b1;
  // Hidden registers answer as errors so software sees the map state
  assign pslverr = psel && penable && !hit;

  assign lockActive = mapLock_ff[`CCR_B_MGMT_LOCK] && !mgmtMode;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state of registers
  always @* begin
    nxt_mgmtSpace   = mgmtSpace_ff;
    nxt_busPower    = busPower_ff;
    nxt_mapLock     = mapLock_ff;
    nxt_ioRecovery  = ioRecovery_ff;
    nxt_regionAlloc = regionAlloc_ff;
    nxt_mgmtModeCtl = mgmtModeCtl_ff;
    if (wrEn) begin
      case (regIdx)
        `CCR_IDX_MGMT_SPC: begin
          nxt_mgmtSpace = merge(mgmtSpace_ff, wrByte, `CCR_MASK_MGMT_SPC,
                                `CCR_LOCK_MGMT_SPC, lockActive);
        end
        `CCR_IDX_BUS_PWR: begin
          nxt_busPower = merge(busPower_ff, wrByte, `CCR_MASK_BUS_PWR,
                               8'h00, 1'b0);
        end
        `CCR_IDX_MAP_LOCK: begin
          nxt_mapLock = merge(mapLock_ff, wrByte, `CCR_MASK_MAP_LOCK,
                              `CCR_LOCK_MAP_LOCK, lockActive);
        end
        `CCR_IDX_IO_REC: begin
          nxt_ioRecovery = merge(ioRecovery_ff, wrByte, `CCR_MASK_IO_REC,
                                 8'h00, 1'b0);
        end
        `CCR_IDX_REG_ALLOC: begin
          nxt_regionAlloc = merge(regionAlloc_ff, wrByte, `CCR_MASK_REG_ALLOC,
                                  8'h00, 1'b0);
        end
        `CCR_IDX_MGMT_MODE: begin
          nxt_mgmtModeCtl = merge(mgmtModeCtl_ff, wrByte, `CCR_MASK_MGMT_MODE,
                                  `CCR_LOCK_MGMT_MODE, lockActive);
        end
        default: begin
          nxt_mgmtSpace = mgmtSpace_ff;
        end
      endcase
    end
    if (mapLock_ff[`CCR_B_MGMT_LOCK]) begin
      nxt_mapLock[`CCR_B_MGMT_LOCK] = 1'b1;
    end
    if (mgmtEntry) begin
      nxt_mgmtModeCtl[`CCR_B_NEST] = 1'b0;
    end else if (resumeFromMgmt) begin
      nxt_mgmtModeCtl[`CCR_B_NEST] = 1'b1;
    end
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mgmtSpace_ff   <= `CCR_RST_MGMT_SPC;
      busPower_ff    <= `CCR_RST_BUS_PWR;
      mapLock_ff     <= `CCR_RST_MAP_LOCK;
      ioRecovery_ff  <= `CCR_RST_IO_REC;
      regionAlloc_ff <= `CCR_RST_REG_ALLOC;
      mgmtModeCtl_ff <= `CCR_RST_MGMT_MODE;
    end else begin
      mgmtSpace_ff   <= nxt_mgmtSpace;
      busPower_ff    <= nxt_busPower;
      mapLock_ff     <= nxt_mapLock;
      ioRecovery_ff  <= nxt_ioRecovery;
      regionAlloc_ff <= nxt_regionAlloc;
      mgmtModeCtl_ff <= nxt_mgmtModeCtl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path; data captured in the setup cycle
  always @* begin
    case (regIdx)
      `CCR_IDX_MGMT_SPC:  rdByte = mgmtSpace_ff;
      `CCR_IDX_BUS_PWR:   rdByte = busPower_ff;
      `CCR_IDX_MAP_LOCK:  rdByte = mapLock_ff;
      `CCR_IDX_IO_REC:    rdByte = ioRecovery_ff;
      `CCR_IDX_REG_ALLOC: rdByte = regionAlloc_ff;
      `CCR_IDX_MGMT_MODE: rdByte = mgmtModeCtl_ff;
      `CCR_IDX_STATUS:    rdByte = {4'h0, lockActive, ioGapBusy, suspended,
                                    mgmtMode};
      default:            rdByte = 8'h00;
    endcase
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= hit ? {24'h000000, rdByte} : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write-policy flag of control register zero
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      notWritethroughFlag <= 1'b0;
    end else if (nwWriteRequest && !busPower_ff[`CCR_B_FREEZE_NW]) begin
      notWritethroughFlag <= nwWriteValue;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus idle insertion
  // idle after burst ready and before strobe
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      busIdle          <= 1'b0;
      strobePending_ff <= 1'b0;
      addressStrobeN   <= 1'b1;
    end else begin
      busIdle          <= busPower_ff[`CCR_B_SLOW_STROBE] && !burstReadyN;
      strobePending_ff <= busPower_ff[`CCR_B_SLOW_STROBE] && strobeRequest;
      addressStrobeN   <= !(busPower_ff[`CCR_B_SLOW_STROBE] ? strobePending_ff
                                                           : strobeRequest);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Burst address order
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      burstAddr <= 2'h0;
    end else if (mapLock_ff[`CCR_B_LIN_BURST]) begin
      burstAddr <= burstFirst + burstBeat;
    end else begin
      burstAddr <= burstFirst ^ burstBeat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Management controls
  // NMI during management
  assign nmiAccept = nmiRequest &&
                     (!mgmtMode || mapLock_ff[`CCR_B_NMI_EN]);
  assign mgmtIntAccept = mgmtInterrupt && mgmtPinsEnable && !mgmtMemoryAccess &&
                         (!mgmtMode || (enhancedMgmtMode &&
                                        mgmtModeCtl_ff[`CCR_B_NEST]));
  assign mgmtPinsEnable    = mgmtSpace_ff[`CCR_B_PINS_EN];
  assign mgmtMemoryAccess  = mgmtSpace_ff[`CCR_B_MEM_ACCESS];
  assign region3WriteAllow = !lockActive;
  assign enhancedMgmtMode  = mgmtModeCtl_ff[`CCR_B_ENH_MODE];

  ////////////////////////////////////////////////////////////////////////////
  // Write protection
  // low region window
  assign writeProtectHit = accessWrite &&
      ((busPower_ff[`CCR_B_LOW_WP] && accessCacheable &&
        accessAddr >= `CCR_LOW_REGION_LO && accessAddr < `CCR_LOW_REGION_HI) ||
       (mgmtModeCtl_ff[`CCR_B_R3_WP] && accessRegion3 && !mgmtMode &&
        regionEnable[3]));

  ////////////////////////////////////////////////////////////////////////////
  // Identification and cache controls
  // ident enable
  assign identFlagWritable    = ioRecovery_ff[`CCR_B_IDENT_EN];
  assign identInvalidOpcode   = identExecute && !ioRecovery_ff[`CCR_B_IDENT_EN];
  assign writethroughAllocate = regionAlloc_ff[`CCR_B_WRITETHROUGH_ALLOCATE];

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : gRegion
      if (g == 3) begin : gThree
        assign regionEnable[g] = regionAlloc_ff[`CCR_B_REGION_EN] ||
                                 mgmtSpace_ff[`CCR_B_R3_SPACE];
      end else begin : gOther
        assign regionEnable[g] = regionAlloc_ff[`CCR_B_REGION_EN];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Sub-blocks
  // I/O spacing
  ccr_io_gap #(
    .CNT_W (`CCR_GAP_CNT_W)
  ) uIoGap (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .gapCode   (ioRecovery_ff[`CCR_B_GAP_HI:`CCR_B_GAP_LO]),
    .ioStart   (ioStart),
    .ioGapBusy (ioGapBusy)
  );

  ccr_suspend uSuspend (
    .sys_clk           (sys_clk),
    .reset_n           (reset_n),
    .pinEnable         (busPower_ff[`CCR_B_SUSPEND_REQUEST_N_PIN]),
    .haltSuspendEnable (busPower_ff[`CCR_B_SUSPEND_REQUEST_N_HALT]),
    .suspendRequestN   (suspendRequestN),
    .haltInstruction   (haltInstruction),
    .wakeEvent         (wakeEvent),
    .suspendAckNOut    (suspendAckNOut),
    .suspendAckNOe     (suspendAckNOe),
    .suspended         (suspended)
  );

endmodule // ccr_regs
`default_nettype wire

// file: core/ccr_suspend.v
// Purpose: Suspend state control from the request pin and from halt.
// Assumes: wakeEvent pulses to leave a halt-entered suspend.
// Notes:   Acknowledge pin is released (enable low) when pins are off.
`timescale 1ns/100ps
`default_nettype none
`include "ccr_map.vh"

module ccr_suspend (
  input  wire sys_clk,
  input  wire reset_n,
  input  wire pinEnable,
  input  wire haltSuspendEnable,
  input  wire suspendRequestN,
  input  wire haltInstruction,
  input  wire wakeEvent,
  output wire suspendAckNOut,
  output wire suspendAckNOe,
  output wire suspended
);

  localparam ST_RUN  = 2'h0;
  localparam ST_PIN  = 2'h1;
  localparam ST_HALT = 2'h2;

  reg [1:0] state_ff;
  reg [1:0] nxt_state;

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RUN: begin
        if (pinEnable && !suspendRequestN) begin
          nxt_state = ST_PIN;
        end else if (haltSuspendEnable && haltInstruction) begin
          nxt_state = ST_HALT;
        end
      end
      ST_PIN: begin
        if (suspendRequestN || !pinEnable) begin
          nxt_state = ST_RUN;
        end
      end
      ST_HALT: begin
        if (wakeEvent) begin
          nxt_state = ST_RUN;
        end
      end
      default: begin
        nxt_state = ST_RUN;
      end
    endcase
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= ST_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign suspended      = (state_ff != ST_RUN);
  assign suspendAckNOe  = pinEnable;
  assign suspendAckNOut = ~suspended;

endmodule // ccr_suspend
`default_nettype wire

// file: verif/ccr_regs_chk.sv
// Purpose: Port-level checks for the configuration register bank.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Bound into every ccr_regs instance.
`timescale 1ns/100ps
`default_nettype none
module ccr_regs_chk (
  input wire logic        sys_clk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        suspendRequestN,
  input wire logic        haltInstruction,
  input wire logic        suspendAckNOe,
  input wire logic        suspended,
  input wire logic        identExecute,
  input wire logic        identFlagWritable,
  input wire logic        identInvalidOpcode,
  input wire logic        accessWrite,
  input wire logic        writeProtectHit,
  input wire logic        strobeRequest,
  input wire logic        addressStrobeN,
  input wire logic [1:0]  burstFirst,
  input wire logic [1:0]  burstBeat,
  input wire logic [1:0]  burstAddr
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////////
  err_phase_a: assert property (pslverr |-> psel && penable)
    else $error("error response outside access phase");
  err_zero_a: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("refused read returned data");
  rsvd_zero_a: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  ident_trap_a: assert property (identInvalidOpcode == (identExecute && !identFlagWritable))
    else $error("ident trap mismatch");
  suspend_request_n_enter_a: assert property (suspendAckNOe && !suspendRequestN |=> suspended)
    else $error("suspend request not honoured");
  suspend_request_n_ignore_a: assert property (!suspendAckNOe && !suspended && !haltInstruction |=> !suspended)
    else $error("suspend entered with pins off");
  wp_write_a: assert property (!accessWrite |-> !writeProtectHit)
    else $error("protect hit on a read");
  strobe_cause_a: assert property ($fell(addressStrobeN) |-> $past(strobeRequest) || $past(strobeRequest, 2))
    else $error("strobe without request");
  burst_order_a: assert property (1'b1 |=> burstAddr == $past(burstFirst) + $past(burstBeat) ||
    burstAddr == ($past(burstFirst) ^ $past(burstBeat)))
    else $error("burst address out of order");
endmodule // ccr_regs_chk
bind ccr_regs ccr_regs_chk ccr_regs_chk_i (.*);
`default_nettype wire

// file: verif/ccr_regs_test.sv
// Purpose: Self-checking bench for the configuration register bank.
// Assumes: Zero-wait APB slave; byte address is index times four.
// Notes:   Inputs change on rising edges by non-blocking assignment.
`timescale 1ns/100ps
`default_nettype none
`include "ccr_map.vh"
`define TB_CHK(g, x) begin nTests++; if ((g) !== (x)) begin errTotal++; \
  $display("mismatch at %0t: got %h exp %h", $time, g, x); end end
module ccr_regs_test;
  localparam logic [9:0] A_SPC = {`CCR_IDX_MGMT_SPC, 2'b00};
  localparam logic [9:0] A_BUS = {`CCR_IDX_BUS_PWR, 2'b00};
  localparam logic [9:0] A_MAP = {`CCR_IDX_MAP_LOCK, 2'b00};
  localparam logic [9:0] A_IO = {`CCR_IDX_IO_REC, 2'b00};
  localparam logic [9:0] A_ALC = {`CCR_IDX_REG_ALLOC, 2'b00};
  localparam logic [9:0] A_MOD = {`CCR_IDX_MGMT_MODE, 2'b00};
  int errTotal = 0, nTests = 0;
  logic sys_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, mgmtMode = 0;
  logic mgmtEntry = 0, resumeFromMgmt = 0, mgmtInterrupt = 0, nmiRequest = 0;
  logic haltInstruction = 0, wakeEvent = 0, suspendRequestN = 1, identExecute = 0;
  logic nwWriteRequest = 0, nwWriteValue = 0, ioStart = 0, burstReadyN = 1;
  logic strobeRequest = 0, accessCacheable = 0, accessWrite = 0, accessRegion3 = 0;
  logic [9:0] paddr = 0;
  logic [31:0] pwdata = 0, accessAddr = 0, rData;
  logic [3:0] pstrb = 4'h1;
  logic [1:0] burstFirst = 0, burstBeat = 0;
  logic rErr;
  wire logic [31:0] prdata;
  wire logic [7:0] regionEnable;
  wire logic [1:0] burstAddr;
  wire logic pready, pslverr, suspendAckNOut, suspendAckNOe, suspended, writeProtectHit;
  wire logic notWritethroughFlag, busIdle, addressStrobeN, nmiAccept, mgmtIntAccept;
  wire logic mgmtPinsEnable, mgmtMemoryAccess, region3WriteAllow, identFlagWritable;
  wire logic identInvalidOpcode, ioGapBusy, writethroughAllocate, enhancedMgmtMode;
  ccr_regs ccr_regs_i (.*);
  always #4 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic stopTest;
    $display("compares %0d mismatches %0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Entered at an edge; waits one edge so psel never changes twice in a step
  task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d);
    int k;
    @(posedge sys_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, 24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      errTotal++;
      stopTest();
    end
    rData = prdata;
    rErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] x, input logic e);
    apb(1'b0, a, 8'h00);
    `TB_CHK({rErr, rData}, {e, 24'h0, x})
  endtask
  task automatic gapCount(output int n);
    @(posedge sys_clk);
    ioStart <= 1'b1;
    @(posedge sys_clk);
    ioStart <= 1'b0;
    n = 0;
    repeat (80) begin
      @(posedge sys_clk);
      if (ioGapBusy === 1'b1) n++;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tReset;
    rd(A_SPC, 8'h00, 1'b0);
    rd(A_BUS, 8'h00, 1'b0);
    rd(A_MAP, 8'h00, 1'b0);
    rd(A_IO, 8'h00, 1'b1);
    rd(10'h309, 8'h00, 1'b1);
    wr(A_MAP, 8'h20);
    rd(A_IO, 8'h00, 1'b1);
    wr(A_MAP, 8'h10);
    rd(A_IO, 8'h05, 1'b0);
    rd(A_ALC, 8'h00, 1'b0);
    rd(A_MOD, 8'h00, 1'b0);
    $display("test reset and map done");
  endtask
  task automatic tMask;
    logic [9:0] a [5] = '{A_SPC, A_BUS, A_IO, A_ALC, A_MOD};
    logic [7:0] m [5] = '{8'h86, 8'h9e, 8'h87, 8'h21, 8'h43};
    for (int i = 0; i < 5; i++) begin
      wr(a[i], 8'hff);
      rd(a[i], m[i], 1'b0);
      wr(a[i], i == 2 ? 8'h05 : 8'h00);
    end
    $display("test reserved bits done");
  endtask
  task automatic tGap;
    int n;
    gapCount(n);
    `TB_CHK(n, 32)
    for (int c = 0; c < 8; c++) begin
      wr(A_IO, 8'(c));
      gapCount(n);
      `TB_CHK(n, c == 7 ? 0 : 1 << c)
    end
    wr(A_IO, 8'h05);
    $display("test io gap done");
  endtask
  task automatic tSusp;
    suspendRequestN <= 1'b0;
    cyc(3);
    `TB_CHK({suspended, suspendAckNOe}, 2'b00)
    wr(A_BUS, 8'h80);
    cyc(2);
    `TB_CHK({suspended, suspendAckNOe, suspendAckNOut}, 3'b110)
    suspendRequestN <= 1'b1;
    wr(A_BUS, 8'h08);
    haltInstruction <= 1'b1;
    cyc(1);
    haltInstruction <= 1'b0;
    cyc(2);
    `TB_CHK(suspended, 1'b1)
    wakeEvent <= 1'b1;
    cyc(1);
    wakeEvent <= 1'b0;
    cyc(2);
    `TB_CHK(suspended, 1'b0)
    $display("test suspend done");
  endtask
  task automatic tNw;
    logic v;
    v = notWritethroughFlag;
    for (int s = 0; s < 2; s++) begin
      wr(A_BUS, s ? 8'h00 : 8'h04);
      {nwWriteRequest, nwWriteValue} <= {1'b1, ~v};
      cyc(1);
      nwWriteRequest <= 1'b0;
      cyc(2);
      `TB_CHK(notWritethroughFlag, s ? ~v : v)
    end
    $display("test write policy freeze done");
  endtask
  task automatic tWp;
    logic [31:0] ad [4] = '{32'h0009ffff, 32'h000a0000, 32'h000fffff, 32'h00100000};
    wr(A_BUS, 8'h10);
    for (int i = 0; i < 5; i++) begin
      {accessAddr, accessCacheable, accessWrite} <= {ad[i % 4 + i / 4], i < 4, 1'b1};
      cyc(2);
      `TB_CHK(writeProtectHit, i == 1 || i == 2)
    end
    wr(A_MOD, 8'h02);
    wr(A_SPC, 8'h80);
    accessRegion3 <= 1'b1;
    cyc(1);
    `TB_CHK(writeProtectHit, 1'b1)
    mgmtMode <= 1'b1;
    cyc(1);
    `TB_CHK(writeProtectHit, 1'b0)
    {mgmtMode, accessRegion3} <= 2'b00;
    wr(A_BUS, 8'h00);
    $display("test low region protect done");
  endtask
  task automatic tStrobe;
    int k;
    for (int s = 0; s < 2; s++) begin
      wr(A_BUS, s ? 8'h02 : 8'h00);
      {strobeRequest, burstReadyN} <= 2'b10;
      cyc(1);
      strobeRequest <= 1'b0;
      k = 1;
      while (addressStrobeN !== 1'b0 && k < 10) begin
        @(posedge sys_clk);
        k++;
      end
      `TB_CHK(k, s + 2)
      `TB_CHK(busIdle, s[0])
      burstReadyN <= 1'b1;
    end
    wr(A_BUS, 8'h00);
    $display("test slow strobe done");
  endtask
  task automatic tMisc;
    identExecute <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      wr(A_IO, s ? 8'h05 : 8'h85);
      cyc(1);
      `TB_CHK({identFlagWritable, identInvalidOpcode}, s ? 2'b01 : 2'b10)
    end
    identExecute <= 1'b0;
    wr(A_ALC, 8'h21);
    cyc(1);
    `TB_CHK({regionEnable, writethroughAllocate}, 9'h1ff)
    wr(A_ALC, 8'h00);
    wr(A_SPC, 8'h80);
    cyc(1);
    `TB_CHK({regionEnable, writethroughAllocate}, 9'h010)
    wr(A_SPC, 8'h00);
    {burstFirst, burstBeat} <= 4'h7;
    for (int s = 0; s < 2; s++) begin
      wr(A_MAP, s ? 8'h10 : 8'h14);
      cyc(2);
      `TB_CHK(burstAddr, s ? 2'h2 : 2'h0)
    end
    $display("test control outputs done");
  endtask
  task automatic tLock;
    mgmtMode <= 1'b1;
    wr(A_MAP, 8'h13);
    mgmtMode <= 1'b0;
    rd(A_MAP, 8'h13, 1'b0);
    wr(A_MAP, 8'h10);
    rd(A_MAP, 8'h13, 1'b0);
    wr(A_MOD, 8'h43);
    rd(A_MOD, 8'h02, 1'b0);
    `TB_CHK(region3WriteAllow, 1'b0)
    {mgmtMode, nmiRequest} <= 2'b11;
    wr(A_MOD, 8'h41);
    rd(A_MOD, 8'h41, 1'b0);
    `TB_CHK({nmiAccept, region3WriteAllow}, 2'b11)
    {mgmtMode, nmiRequest} <= 2'b00;
    reset_n <= 1'b0;
    cyc(3);
    reset_n <= 1'b1;
    rd(A_MAP, 8'h00, 1'b0);
    $display("test management lock done");
  endtask
  task automatic tNest;
    wr(A_MAP, 8'h10);
    {mgmtMode, nmiRequest, mgmtInterrupt} <= 3'b111;
    wr(A_MOD, 8'h41);
    wr(A_SPC, 8'h02);
    cyc(1);
    `TB_CHK({nmiAccept, enhancedMgmtMode, mgmtIntAccept}, 3'b011)
    mgmtEntry <= 1'b1;
    cyc(1);
    mgmtEntry <= 1'b0;
    rd(A_MOD, 8'h01, 1'b0);
    `TB_CHK(mgmtIntAccept, 1'b0)
    resumeFromMgmt <= 1'b1;
    cyc(1);
    resumeFromMgmt <= 1'b0;
    rd(A_MOD, 8'h41, 1'b0);
    `TB_CHK({mgmtIntAccept, mgmtPinsEnable, mgmtMemoryAccess}, 3'b110)
    {mgmtMode, nmiRequest, mgmtInterrupt} <= 3'b000;
    $display("test nesting done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(3);
    reset_n <= 1'b1;
    tReset();
    tMask();
    tGap();
    tSusp();
    tNw();
    tWp();
    tStrobe();
    tMisc();
    tLock();
    tNest();
    stopTest();
  end
endmodule // ccr_regs_test
`default_nettype wire
